/* File: hdl/ris_pkg.sv */
package ris_pkg;

    localparam int NUM_IN = 4;
    localparam int IDX_W  = 2;
    localparam int PRIO_W = 3;
    localparam int TYPE_W = 4;
    localparam int VCNT_W = 16;

    // priority value that keeps an input out of the priority search (manual choice can still select it)
    localparam logic [PRIO_W-1:0] PRIO_NEVER = 3'h0;

    // buffer type codes
    localparam logic [TYPE_W-1:0] TYPE_DC_EXT  = 4'h0;
    localparam logic [TYPE_W-1:0] TYPE_AC_EXT  = 4'h1;
    localparam logic [TYPE_W-1:0] TYPE_DC_D100 = 4'h2;
    localparam logic [TYPE_W-1:0] TYPE_AC_D100 = 4'h3;
    localparam logic [TYPE_W-1:0] TYPE_DC_S50  = 4'h4;
    localparam logic [TYPE_W-1:0] TYPE_AC_S50  = 4'h5;
    localparam logic [TYPE_W-1:0] TYPE_CMOS    = 4'h8;
    localparam logic [TYPE_W-1:0] TYPE_CMOS_50 = 4'hc;

    localparam logic DC_PATH_OFF = 1'b0;
    localparam logic DC_PATH_ON  = 1'b1;

    // values after reset
    localparam logic [IDX_W-1:0]  REF_RST  = 2'h0;
    localparam logic [VCNT_W-1:0] VCNT_RST = 16'h0;
    localparam logic              SW_RST   = 1'b0;

    typedef enum logic [1:0] {
        RIS_AUTO_REV     = 2'h0,
        RIS_AUTO_NONREV  = 2'h1,
        RIS_MAN_FALLBACK = 2'h2,
        RIS_MAN_HOLDOVER = 2'h3
    } ris_mode_t;

    typedef enum logic [1:0] {
        ST_FREE  = 2'h0,
        ST_TRACK = 2'h1,
        ST_HOLD  = 2'h3
    } ris_state_t;

endpackage : ris_pkg

/* File: hdl/ris_buf_decode.sv */
`timescale 1ns/100ps
module ris_buf_decode
    import ris_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              reset,
    input  wire logic              input_dc_path_enable,
    input  wire logic [TYPE_W-1:0] input_buffer_type_code,
    output logic                   single_end_term_switch,
    output logic                   diff_term_switch,
    output logic                   input_bias_switch,
    output logic                   ac_cap_bypass_switch,
    output logic                   amp_detect_enable
);

    logic next_se;
    logic next_diff;
    logic next_bias;
    logic next_byp;

    always_comb begin
        next_se   = 1'b0;
        next_diff = 1'b0;
        next_bias = 1'b0;
        next_byp  = 1'b0;
        if (input_dc_path_enable == DC_PATH_OFF) begin
            // R3 type code decode
            case (input_buffer_type_code)
                TYPE_AC_EXT:  next_bias = 1'b1;
                TYPE_DC_D100: next_diff = 1'b1;
                TYPE_AC_D100: begin
                    next_diff = 1'b1;
                    next_bias = 1'b1;
                end
                TYPE_DC_S50:  next_se = 1'b1;
                TYPE_AC_S50:  begin
                    next_se   = 1'b1;
                    next_bias = 1'b1;
                end
                default:      next_se = 1'b0;
            endcase
        end else begin
            // R4 capacitor bypass
            case (input_buffer_type_code)
                TYPE_CMOS:    next_byp = 1'b1;
                TYPE_CMOS_50: begin
                    next_byp = 1'b1;
                    next_se  = 1'b1;
                end
                default:      next_byp = 1'b0;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            single_end_term_switch <= SW_RST;
            diff_term_switch       <= SW_RST;
            input_bias_switch      <= SW_RST;
            ac_cap_bypass_switch   <= SW_RST;
            amp_detect_enable      <= SW_RST;
        end else begin
            single_end_term_switch <= next_se;
            diff_term_switch       <= next_diff;
            input_bias_switch      <= next_bias;
            ac_cap_bypass_switch   <= next_byp;
            // R5 amplitude detector use
            amp_detect_enable      <= !next_byp
                && input_buffer_type_code != TYPE_CMOS
                && input_buffer_type_code != TYPE_CMOS_50;
        end
    end

endmodule : ris_buf_decode

/* File: hdl/ris_valid_timer.sv */
`timescale 1ns/100ps
module ris_valid_timer
    import ris_pkg::*;
#(
    parameter int CNT_W = VCNT_W
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic             monitor_flag,
    input  wire logic [CNT_W-1:0] validation_time,
    output logic                  input_valid
);

    logic [CNT_W-1:0] clear_count;

    // R19 qualify after clear time
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            clear_count <= CNT_W'(VCNT_RST);
            input_valid <= 1'b0;
        end else if (monitor_flag) begin
            clear_count <= CNT_W'(VCNT_RST);
            input_valid <= 1'b0;
        end else if (clear_count >= validation_time) begin
            input_valid <= 1'b1;
        end else begin
            clear_count <= clear_count + CNT_W'(1);
        end
    end

endmodule : ris_valid_timer

/* File: hdl/ris_selector.sv */
// How it works
// R1 - any one of four inputs can be routed to the dpll
// R2 - inputs of different rates allowed; dividers bring them to one rate
// R3 - with dc path off, type code sets termination and bias switches
// R4 - dc path on with cmos types closes bypass; 0x0c adds 50 ohm
// R5 - amplitude detector for non-CMOS inputs, bypass open only
// R6 - selection automatic by priority or manual, chosen by mode setting
// R7 - priority 0 to 7; 0 never selected, 1 best; code still tracks a priority-0 input chosen in manual modes
// R8 - equal priorities: lower input index wins
// R9 - selected input shown on status pins and status register
// R10 - revertive: always best valid input, switch at once
// R11 - non-revertive: keep current input until it turns invalid
// R12 - manual fallback: manual input until invalid, then best valid
// R13 - nothing valid: holdover with valid history, else free-run; code never goes from free-run to holdover, even with valid history
// R14 - manual holdover: manual input invalid means holdover or free-run
// R15 - manual modes resume tracking when chosen input is valid again
// R16 - manual choice comes from register or from select pins
// R17 - hitless switch by phase cancellation, slew limit separately
// R18 - hitless off: phase step passes, filtered by loop
// R19 - input valid only after monitors clear for validation time
// R20 - four selection modes have distinct codes
// R21 - selection and holdover changes on one control clock edge
`timescale 1ns/100ps
module ris_selector
    import ris_pkg::*;
#(
    parameter int CNT_W = VCNT_W
) (
    input  wire logic                     core_clk,
    input  wire logic                     reset,
    input  wire logic [NUM_IN-1:0]        input_dc_path_enable,
    input  wire logic [NUM_IN*TYPE_W-1:0] input_buffer_type_code,
    input  wire logic [NUM_IN*PRIO_W-1:0] reference_priority,
    input  wire logic [NUM_IN-1:0]        monitor_flag,
    input  wire logic [CNT_W-1:0]         validation_time,
    input  wire logic [1:0]               selection_mode,
    input  wire logic [IDX_W-1:0]         manual_reference_choice,
    input  wire logic [IDX_W-1:0]         pin_reference_choice,
    input  wire logic                     pin_select_enable,
    input  wire logic                     tuning_history_valid,
    input  wire logic                     hitless_enable,
    input  wire logic                     phase_slew_enable,
    output logic [NUM_IN-1:0]             single_end_term_switch,
    output logic [NUM_IN-1:0]             diff_term_switch,
    output logic [NUM_IN-1:0]             input_bias_switch,
    output logic [NUM_IN-1:0]             ac_cap_bypass_switch,
    output logic [NUM_IN-1:0]             amp_detect_enable,
    output logic [NUM_IN-1:0]             input_valid,
    output logic [IDX_W-1:0]              active_reference,
    output logic [IDX_W-1:0]              selected_ref_pin,
    output logic [IDX_W-1:0]              selected_ref_status,
    output logic                          tracking,
    output logic                          holdover,
    output logic                          free_run,
    output logic                          ref_switch,
    output logic                          phase_cancel_start,
    output logic                          phase_slew_start,
    output logic                          phase_step_pass
);

    ////////////////////////////////////////////////////////////////////////

    ris_state_t       state;
    ris_state_t       next_state;
    ris_mode_t        mode;
    logic [IDX_W-1:0] next_ref;
    logic [IDX_W-1:0] man_idx;
    logic [IDX_W:0]   best;
    logic             best_found;
    logic [IDX_W-1:0] best_idx;
    logic             next_switch;
    logic             lost_state_hold;
    logic [NUM_IN-1:0] valid_d;

    ////////////////////////////////////////////////////////////////////////
    // input buffers and validation

    for (genvar i = 0; i < NUM_IN; i++) begin : g_in
        ris_buf_decode u_dec (
            .core_clk               (core_clk),
            .reset                  (reset),
            .input_dc_path_enable   (input_dc_path_enable[i]),
            .input_buffer_type_code (input_buffer_type_code[i*TYPE_W +:
                                                            TYPE_W]),
            .single_end_term_switch (single_end_term_switch[i]),
            .diff_term_switch       (diff_term_switch[i]),
            .input_bias_switch      (input_bias_switch[i]),
            .ac_cap_bypass_switch   (ac_cap_bypass_switch[i]),
            .amp_detect_enable      (amp_detect_enable[i])
        );
        ris_valid_timer #(.CNT_W(CNT_W)) u_vt (
            .core_clk        (core_clk),
            .reset           (reset),
            .monitor_flag    (monitor_flag[i]),
            .validation_time (validation_time),
            .input_valid     (input_valid[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // priority search

    function automatic logic [PRIO_W-1:0] prio_of(
        input logic [NUM_IN*PRIO_W-1:0] prios,
        input logic [IDX_W-1:0]         idx
    );
        prio_of = prios[idx*PRIO_W +: PRIO_W];
    endfunction : prio_of

    function automatic logic [IDX_W:0] best_pick(
        input logic [NUM_IN-1:0]        valid,
        input logic [NUM_IN*PRIO_W-1:0] prios
    );
        logic              found;
        logic [IDX_W-1:0]  idx;
        logic [PRIO_W-1:0] bp;
        logic [PRIO_W-1:0] p;
        found = 1'b0;
        idx   = REF_RST;
        bp    = PRIO_NEVER;
        for (int i = 0; i < NUM_IN; i++) begin
            p = prio_of(prios, IDX_W'(i));
            // R7 zero is never chosen
            // R8 strict compare keeps lower index
            if (valid[i] && p != PRIO_NEVER && (!found || p < bp)) begin
                found = 1'b1;
                idx   = IDX_W'(i);
                bp    = p;
            end
        end
        best_pick = {found, idx};
    endfunction : best_pick

    assign best       = best_pick(input_valid, reference_priority);
    assign best_found = best[IDX_W];
    assign best_idx   = best[IDX_W-1:0];

    // R20 mode codes
    assign mode = ris_mode_t'(selection_mode);

    // R16 register or pin choice
    assign man_idx = pin_select_enable ? pin_reference_choice
                                       : manual_reference_choice;

    // R13 holdover only with history
    assign lost_state_hold = tuning_history_valid && state != ST_FREE;

    ////////////////////////////////////////////////////////////////////////
    // selection state machine

    always_comb begin
        next_ref   = active_reference;
        next_state = lost_state_hold ? ST_HOLD : ST_FREE;
        // R6 automatic or manual
        case (mode)
            RIS_AUTO_REV: begin
                // R10 best valid at once
                if (best_found) begin
                    next_state = ST_TRACK;
                    next_ref   = best_idx;
                end
            end
            RIS_AUTO_NONREV: begin
                // R11 hold current while valid
                if (state == ST_TRACK && input_valid[active_reference]) begin
                    next_state = ST_TRACK;
                end else if (best_found) begin
                    next_state = ST_TRACK;
                    next_ref   = best_idx;
                end
            end
            RIS_MAN_FALLBACK: begin
                // R12 manual then fallback
                // R15 resume on chosen input
                if (input_valid[man_idx]) begin
                    next_state = ST_TRACK;
                    next_ref   = man_idx;
                end else if (best_found) begin
                    next_state = ST_TRACK;
                    next_ref   = best_idx;
                end
            end
            RIS_MAN_HOLDOVER: begin
                // R14 no fallback
                if (input_valid[man_idx]) begin
                    next_state = ST_TRACK;
                    next_ref   = man_idx;
                end
            end
            default: begin
                next_state = ST_FREE;
            end
        endcase
    end

    assign next_switch = next_state == ST_TRACK
        && (state != ST_TRACK || next_ref != active_reference);

    // R21 single edge update
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state <= ST_FREE;
        end else begin
            state <= next_state;
        end
    end

    // R1 mux select
    // R2 common rate after dividers
    // R9 pins and status
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            active_reference    <= REF_RST;
            selected_ref_pin    <= REF_RST;
            selected_ref_status <= REF_RST;
        end else begin
            active_reference    <= next_ref;
            selected_ref_pin    <= next_ref;
            selected_ref_status <= next_ref;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            tracking <= 1'b0;
            holdover <= 1'b0;
            free_run <= 1'b1;
        end else begin
            tracking <= next_state == ST_TRACK;
            holdover <= next_state == ST_HOLD;
            free_run <= next_state == ST_FREE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // hitless switching controls

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ref_switch         <= 1'b0;
            phase_cancel_start <= 1'b0;
            phase_slew_start   <= 1'b0;
            phase_step_pass    <= 1'b1;
        end else begin
            ref_switch         <= next_switch;
            // R17 cancel and optional slew
            phase_cancel_start <= next_switch && hitless_enable;
            phase_slew_start   <= next_switch && hitless_enable
                                  && phase_slew_enable;
            // R18 step passes when off
            phase_step_pass    <= !hitless_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            valid_d <= '0;
        end else begin
            valid_d <= input_valid;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    AST_TRACK_ON_VALID: // R19
        assert property (state == ST_TRACK |-> valid_d[active_reference])
        else $error("tracking an input that was not valid");

    AST_AUTO_NO_PRIO0: // R7
        assert property ((mode == RIS_AUTO_REV || mode == RIS_AUTO_NONREV)
            && next_state == ST_TRACK
            |=> prio_of(reference_priority, active_reference) != PRIO_NEVER
                || $changed(reference_priority))
        else $error("auto mode picked a never-select input");

    AST_REVERT_BEST: // R10
        assert property (mode == RIS_AUTO_REV && best_found
            |=> state == ST_TRACK && active_reference == $past(best_idx))
        else $error("revertive mode missed the best input");

    AST_NONREV_KEEP: // R11
        assert property (mode == RIS_AUTO_NONREV && state == ST_TRACK
            && input_valid[active_reference]
            |=> $stable(active_reference) && state == ST_TRACK)
        else $error("non-revertive mode left a valid input");

    AST_MAN_RESUME: // R15
        assert property (selection_mode[1] && input_valid[man_idx]
            |=> state == ST_TRACK && active_reference == $past(man_idx))
        else $error("manual mode did not track chosen input");

    AST_MAN_NO_FALLBACK: // R14
        assert property (mode == RIS_MAN_HOLDOVER && !input_valid[man_idx]
            |=> state != ST_TRACK)
        else $error("manual holdover mode fell back");

    AST_HOLD_OR_FREE: // R13
        assert property (mode == RIS_MAN_FALLBACK && !best_found
            && !input_valid[man_idx] && state == ST_TRACK
            |=> (holdover == $past(tuning_history_valid))
                && (free_run != $past(tuning_history_valid)))
        else $error("wrong holdover or free-run entry");

    AST_STATUS_MATCH: // R9
        assert property (tracking |-> selected_ref_pin == active_reference
            && selected_ref_status == active_reference)
        else $error("status outputs disagree with selection");

    AST_CANCEL_ON_SWITCH: // R17
        assert property (next_switch && hitless_enable
            |=> phase_cancel_start && ref_switch
                && phase_slew_start == $past(phase_slew_enable)
                ##1 (!ref_switch || $past(next_switch)))
        else $error("phase cancel not started on switch");

endmodule : ris_selector

/* File: verification/ris_ref_source_model.sv */
`timescale 1ns/100ps
module ris_ref_source_model
    import ris_pkg::*;
(
    input  wire logic [NUM_IN-1:0] source_on,
    output logic      [NUM_IN-1:0] monitor_flag
);
////////////////////////////////////////////////////////////////////////////
    // a missing source trips its monitors, a present one clears them
    assign monitor_flag = ~source_on;
endmodule : ris_ref_source_model

/* File: verification/test_ris_selector.sv */
`timescale 1ns/100ps
module test_ris_selector
    import ris_pkg::*;
;
    localparam int VT = 3;
    logic        core_clk = 1'b0;
    logic        reset    = 1'b1;
    logic [3:0]  dc_en    = 4'h0;
    logic [15:0] btype    = 16'h0;
    logic [11:0] prio     = {3'h0, 3'h2, 3'h1, 3'h2};
    logic [3:0]  src_on   = 4'h0;
    logic [3:0]  mflag;
    logic [1:0]  mode     = 2'h0;
    logic [1:0]  man_ch   = 2'h0;
    logic [1:0]  pin_ch   = 2'h0;
    logic        pin_en   = 1'b0;
    logic        hist     = 1'b1;
    logic        hitless  = 1'b1;
    logic        slew     = 1'b1;
    logic [3:0]  s1, s2, s3, s4, amp, vld;
    logic [1:0]  act, ref_pin, ref_st;
    logic        trk, hold, free, rsw, pcs, pss, psp;
    int          bad_count = 0;
    int          cmp_count = 0;
    int          n_sw      = 0;
    int          n_pc      = 0;
    int          n_ps      = 0;
    int          pc_mark;
    logic [9:0]  dec_tab [10] = '{
        {1'b0, TYPE_DC_EXT, 5'b00001}, {1'b0, TYPE_AC_EXT, 5'b00101},
        {1'b0, TYPE_DC_D100, 5'b01001}, {1'b0, TYPE_AC_D100, 5'b01101},
        {1'b0, TYPE_DC_S50, 5'b10001}, {1'b0, TYPE_AC_S50, 5'b10101},
        {1'b0, TYPE_CMOS, 5'b00000}, {1'b0, 4'h6, 5'b00001},
        {1'b1, TYPE_CMOS, 5'b00010}, {1'b1, TYPE_CMOS_50, 5'b10010}};

    always #20 core_clk = ~core_clk;

    ris_ref_source_model src (
        .source_on    (src_on),
        .monitor_flag (mflag)
    );

    ris_selector #(.CNT_W(16)) uut (
        .core_clk                (core_clk),
        .reset                   (reset),
        .input_dc_path_enable    (dc_en),
        .input_buffer_type_code  (btype),
        .reference_priority      (prio),
        .monitor_flag            (mflag),
        .validation_time         (16'(VT)),
        .selection_mode          (mode),
        .manual_reference_choice (man_ch),
        .pin_reference_choice    (pin_ch),
        .pin_select_enable       (pin_en),
        .tuning_history_valid    (hist),
        .hitless_enable          (hitless),
        .phase_slew_enable       (slew),
        .single_end_term_switch  (s1),
        .diff_term_switch        (s2),
        .input_bias_switch       (s3),
        .ac_cap_bypass_switch    (s4),
        .amp_detect_enable       (amp),
        .input_valid             (vld),
        .active_reference        (act),
        .selected_ref_pin        (ref_pin),
        .selected_ref_status     (ref_st),
        .tracking                (trk),
        .holdover                (hold),
        .free_run                (free),
        .ref_switch              (rsw),
        .phase_cancel_start      (pcs),
        .phase_slew_start        (pss),
        .phase_step_pass         (psp)
    );

    // pulses counted mid-cycle, away from the launching edge
    always @(negedge core_clk) begin
        if (rsw === 1'b1) n_sw++;
        if (pcs === 1'b1) n_pc++;
        if (pss === 1'b1) n_ps++;
    end

////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic check_bit(string nm, logic e, logic g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s exp %b got %b", nm, e, g);
        end
    endtask : check_bit

    task automatic check_vec(string nm, logic [4:0] e, logic [4:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s exp %b got %b", nm, e, g);
        end
    endtask : check_vec

    task automatic check_cnt(string nm, int e, int g);
        cmp_count++;
        if (g != e) begin
            bad_count++;
            $display("CHECK FAILED %s exp %0d got %0d", nm, e, g);
        end
    endtask : check_cnt

    task automatic step(int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step

    // st is {tracking, holdover, free_run}; idx counts only when tracking
    task automatic wait_for(logic [2:0] st, logic [1:0] idx);
        int k;
        k = 0;
        while (k < 60 && !({trk, hold, free} === st &&
               (st !== 3'b100 || act === idx))) begin
            step(1);
            k++;
        end
        check_vec("state", {2'h0, st}, {2'h0, trk, hold, free});
        if (k == 60) begin
            bad_count++;
            report_and_stop();
        end
        if (st === 3'b100) begin
            check_vec("mux", {3'h0, idx}, {3'h0, act});
            check_vec("status pin", {3'h0, idx}, {3'h0, ref_pin});
            check_vec("status reg", {3'h0, idx}, {3'h0, ref_st});
        end
    endtask : wait_for

////////////////////////////////////////////////////////////////////////////
    initial begin
        step(8);
        check_bit("free_run", 1'b1, free);
        check_vec("valid", 5'h00, {1'b0, vld});
        @(posedge core_clk);
        reset <= 1'b0;
        step(3);
        check_bit("step pass", 1'b0, psp);
        $display("test reset done");
        for (int k = 0; k < 10; k++) begin
            int i;
            i = k % 4;
            @(posedge core_clk);
            dc_en[i] <= dec_tab[k][9];
            btype[4*i +: 4] <= dec_tab[k][8:5];
            step(2);
            check_vec("switches", dec_tab[k][4:0],
                      {s1[i], s2[i], s3[i], s4[i], amp[i]});
        end
        $display("test decode done");
        @(posedge core_clk);
        src_on[3] <= 1'b1;
        step(VT);
        check_bit("valid early", 1'b0, vld[3]);
        step(1);
        check_bit("valid", 1'b1, vld[3]);
        step(4);
        check_bit("free_run", 1'b1, free);
        $display("test validation done");
        @(posedge core_clk);
        src_on <= 4'b1101;
        wait_for(3'b100, 2'h0);
        @(posedge core_clk);
        src_on[1] <= 1'b1;
        wait_for(3'b100, 2'h1);
        step(2);
        check_cnt("switches", 2, n_sw);
        check_cnt("cancel", n_sw, n_pc);
        check_cnt("slew", n_sw, n_ps);
        $display("test revertive done");
        @(posedge core_clk);
        mode <= RIS_AUTO_NONREV;
        slew <= 1'b0;
        src_on[1] <= 1'b0;
        wait_for(3'b100, 2'h0);
        @(posedge core_clk);
        src_on[1] <= 1'b1;
        step(VT + 8);
        check_vec("kept", 5'h00, {3'h0, act});
        @(posedge core_clk);
        src_on[0] <= 1'b0;
        wait_for(3'b100, 2'h1);
        $display("test non-revertive done");
        @(posedge core_clk);
        mode <= RIS_MAN_FALLBACK;
        man_ch <= 2'h2;
        pin_ch <= 2'h3;
        wait_for(3'b100, 2'h2);
        @(posedge core_clk);
        src_on[2] <= 1'b0;
        wait_for(3'b100, 2'h1);
        @(posedge core_clk);
        src_on[2] <= 1'b1;
        wait_for(3'b100, 2'h2);
        @(posedge core_clk);
        pin_en <= 1'b1;
        wait_for(3'b100, 2'h3);
        @(posedge core_clk);
        src_on <= 4'h0;
        wait_for(3'b010, 2'h0);
        @(posedge core_clk);
        src_on[3] <= 1'b1;
        wait_for(3'b100, 2'h3);
        $display("test fallback done");
        @(posedge core_clk);
        mode <= RIS_MAN_HOLDOVER;
        pin_en <= 1'b0;
        hitless <= 1'b0;
        src_on <= 4'b0110;
        pc_mark = n_pc;
        wait_for(3'b100, 2'h2);
        @(posedge core_clk);
        src_on[2] <= 1'b0;
        wait_for(3'b010, 2'h0);
        step(VT + 8);
        check_bit("holdover", 1'b1, hold);
        @(posedge core_clk);
        src_on[2] <= 1'b1;
        wait_for(3'b100, 2'h2);
        @(posedge core_clk);
        hist <= 1'b0;
        src_on[2] <= 1'b0;
        wait_for(3'b001, 2'h0);
        check_bit("step pass", 1'b1, psp);
        check_cnt("cancel off", pc_mark, n_pc);
        check_cnt("slew off", 2, n_ps);
        $display("test holdover done");
        report_and_stop();
    end
endmodule : test_ris_selector
